// File: logic/arf_map.svh
`ifndef ARF_MAP_SVH
`define ARF_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses; channel base is address bits 7:5)
// ----------------------------------------
`define ARF_OFS_CTRL      8'h00
`define ARF_OFS_MODE      8'h04
`define ARF_OFS_CHEN      8'h10
`define ARF_OFS_STATUS    8'h1C
`define ARF_OFS_LAST      8'h20
`define ARF_OFS_IRQ_STAT  8'h24
`define ARF_OFS_IRQ_MASK  8'h28
`define ARF_OFS_CHAN_BASE 3'h2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ARF_CTRL_START    0
`define ARF_MODE_SLEEP    0
`define ARF_ST_EOC_LO     0
`define ARF_ST_COV_LO     8
`define ARF_ST_NEW_DATA   16
`define ARF_ST_ANY_OV     17
`define ARF_ST_ASLEEP     18
`define ARF_LAST_CHAN_LO  12
`define ARF_IRQ_DATA      0
`define ARF_IRQ_OVERRUN   1
`define ARF_IRQ_SLEEP     2
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define ARF_NUM_CHAN      8
`define ARF_DATA_W        10
`define ARF_IRQ_W         3
`define ARF_CHEN_RST      8'h00
`define ARF_IRQ_MASK_RST  3'h0

`endif

// File: logic/arf_pkg.sv
`default_nettype none
package arf_pkg;
    typedef logic [2:0] arf_chan_t;
    typedef logic [9:0] arf_data_t;
    typedef logic [7:0] arf_addr_t;
    typedef enum logic {
        ARF_AWAKE,
        ARF_ASLEEP
    } arf_pwr_t;
endpackage
`default_nettype wire

// File: logic/arf_result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module arf_result_mem (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Write port
    input  wire logic             wr_en,
    input  wire arf_pkg::arf_chan_t wr_addr,
    input  wire arf_pkg::arf_data_t wr_data,
    // Read port, also carries the register file's read value
    input  wire logic             rd_en,
    input  wire logic             rd_sel_mem,
    input  wire arf_pkg::arf_chan_t rd_addr,
    input  wire logic [31:0]      rd_alt,
    output logic [31:0]           rd_data
);
    arf_pkg::arf_data_t mem_reg [0:7];
    logic [31:0]        rd_data_reg;
    logic [31:0]        rd_data_next;

    // Data stand only in the cycle after the read
    always_comb begin
        rd_data_next = 32'h0000_0000;
        if (rd_en) begin
            rd_data_next = rd_sel_mem ? {22'h000000, mem_reg[rd_addr]} : rd_alt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 32'h0000_0000;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule
`default_nettype wire

// File: logic/arf_flag_ctrl.sv
// What this block does
// - Only last-result read clears new data flag
// - Disabled-channel completion never sets new data
// - Channel read never blocks new data set
// - Disable elsewhere still stores and flags data
// - Status read updates any-overrun with completion
// - Completion with new data flag set raises any-overrun
// - Disable elsewhere still raises any-overrun
// - Completion with unread result sets channel overrun
// - Status read clears channel overrun flags
// - Result read clears that channel's completion
// - Disabled channel never raises its completion
// - Channel read clears only its own completion
// - Sleep entered only at conversion end
`timescale 1ns/1ps
`default_nettype none
`include "arf_map.svh"
module arf_flag_ctrl (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Register port
    input  wire arf_pkg::arf_addr_t bus_addr,
    input  wire logic [31:0]        bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output logic [31:0]             bus_rdata,
    // Conversion core
    input  wire logic               eoc_pulse,
    input  wire arf_pkg::arf_chan_t eoc_chan,
    input  wire arf_pkg::arf_data_t eoc_data,
    output logic                    start_conv,
    output logic                    analog_sleep,
    output logic [7:0]              chan_enable,
    // Interrupt
    output logic                    irq
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic [7:0] chan_onehot(input arf_pkg::arf_chan_t ch);
        chan_onehot = 8'h01 << ch;
    endfunction

    logic               wr_ctrl;
    logic               wr_mode;
    logic               wr_chen;
    logic               wr_irq_stat;
    logic               wr_irq_mask;
    logic               rd_status;
    logic               rd_last;
    logic               rd_chan;
    arf_pkg::arf_chan_t rd_ch;

    assign wr_ctrl     = bus_wr && bus_addr == `ARF_OFS_CTRL;
    assign wr_mode     = bus_wr && bus_addr == `ARF_OFS_MODE;
    assign wr_chen     = bus_wr && bus_addr == `ARF_OFS_CHEN;
    assign wr_irq_stat = bus_wr && bus_addr == `ARF_OFS_IRQ_STAT;
    assign wr_irq_mask = bus_wr && bus_addr == `ARF_OFS_IRQ_MASK;
    assign rd_status   = bus_rd && bus_addr == `ARF_OFS_STATUS;
    assign rd_last     = bus_rd && bus_addr == `ARF_OFS_LAST;
    assign rd_chan     = bus_rd && bus_addr[7:5] == `ARF_OFS_CHAN_BASE
                         && bus_addr[1:0] == 2'h0;
    assign rd_ch       = bus_addr[4:2];

    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    logic [7:0]                 chen_reg;
    logic [7:0]                 chen_next;
    logic                       sleep_sel_reg;
    logic                       sleep_sel_next;
    logic                       start_reg;
    logic                       start_next;
    logic [`ARF_IRQ_W-1:0]      irq_mask_reg;
    logic [`ARF_IRQ_W-1:0]      irq_mask_next;

    always_comb begin
        chen_next      = wr_chen ? bus_wdata[7:0] : chen_reg;
        sleep_sel_next = wr_mode ? bus_wdata[`ARF_MODE_SLEEP] : sleep_sel_reg;
        start_next     = wr_ctrl && bus_wdata[`ARF_CTRL_START];
        irq_mask_next  = wr_irq_mask ? bus_wdata[`ARF_IRQ_W-1:0] : irq_mask_reg;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chen_reg      <= `ARF_CHEN_RST;
            sleep_sel_reg <= 1'b0;
            start_reg     <= 1'b0;
            irq_mask_reg  <= `ARF_IRQ_MASK_RST;
        end else begin
            chen_reg      <= chen_next;
            sleep_sel_reg <= sleep_sel_next;
            start_reg     <= start_next;
            irq_mask_reg  <= irq_mask_next;
        end
    end

    // ----------------------------------------
    // Conversion flags
    // ----------------------------------------
    // Enable is judged after this cycle's write, so a channel switched off
    // during its own conversion is dropped, while other channels are not.
    logic                       accept;
    logic [7:0]                 eoc_hot;
    logic [7:0]                 eoc_reg;
    logic [7:0]                 eoc_next;
    logic [7:0]                 eoc_clr;
    logic [7:0]                 cov_reg;
    logic [7:0]                 cov_next;
    logic [7:0]                 cov_set;
    logic                       new_data_reg;
    logic                       new_data_next;
    logic                       any_ov_reg;
    logic                       any_ov_next;
    logic                       any_ov_set;
    arf_pkg::arf_data_t         last_data_reg;
    arf_pkg::arf_data_t         last_data_next;
    arf_pkg::arf_chan_t         last_chan_reg;
    arf_pkg::arf_chan_t         last_chan_next;

    assign accept  = eoc_pulse && chen_next[eoc_chan];
    assign eoc_hot = accept ? chan_onehot(eoc_chan) : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < `ARF_NUM_CHAN; gi++) begin : g_cov
            assign cov_set[gi] = eoc_hot[gi] && eoc_reg[gi];
        end
    endgenerate

    // New data over an unread one is a general overrun
    assign any_ov_set = accept && new_data_reg;

    always_comb begin
        eoc_clr = 8'h00;
        if (rd_chan) begin
            eoc_clr = eoc_clr | chan_onehot(rd_ch);
        end
        if (rd_last) begin
            eoc_clr = eoc_clr | chan_onehot(last_chan_reg);
        end
        eoc_next = (eoc_reg & ~eoc_clr) | eoc_hot;
        cov_next = (rd_status ? 8'h00 : cov_reg) | cov_set;
        if (accept) begin
            new_data_next = 1'b1;
        end else if (rd_last) begin
            new_data_next = 1'b0;
        end else begin
            new_data_next = new_data_reg;
        end
        any_ov_next = (rd_status ? 1'b0 : any_ov_reg) | any_ov_set;
        last_data_next = accept ? eoc_data : last_data_reg;
        last_chan_next = accept ? eoc_chan : last_chan_reg;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eoc_reg       <= 8'h00;
            cov_reg       <= 8'h00;
            new_data_reg  <= 1'b0;
            any_ov_reg    <= 1'b0;
            last_data_reg <= 10'h000;
            last_chan_reg <= 3'h0;
        end else begin
            eoc_reg       <= eoc_next;
            cov_reg       <= cov_next;
            new_data_reg  <= new_data_next;
            any_ov_reg    <= any_ov_next;
            last_data_reg <= last_data_next;
            last_chan_reg <= last_chan_next;
        end
    end

    // ----------------------------------------
    // Sleep control
    // ----------------------------------------
    // An idle converter has no end of conversion to sleep at; software
    // must start one after selecting sleep.
    arf_pkg::arf_pwr_t pwr_reg;
    arf_pkg::arf_pwr_t pwr_next;
    logic              sleep_ev;

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            arf_pkg::ARF_AWAKE: begin
                if (eoc_pulse && sleep_sel_reg) begin
                    pwr_next = arf_pkg::ARF_ASLEEP;
                end
            end
            arf_pkg::ARF_ASLEEP: begin
                if (start_next || !sleep_sel_next) begin
                    pwr_next = arf_pkg::ARF_AWAKE;
                end
            end
        endcase
    end

    assign sleep_ev = pwr_reg == arf_pkg::ARF_AWAKE && pwr_next == arf_pkg::ARF_ASLEEP;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_reg <= arf_pkg::ARF_AWAKE;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    logic [`ARF_IRQ_W-1:0] irq_stat_reg;
    logic [`ARF_IRQ_W-1:0] irq_stat_next;
    logic [`ARF_IRQ_W-1:0] irq_ev;
    logic                  irq_reg;
    logic                  irq_next;

    always_comb begin
        irq_ev                   = '0;
        irq_ev[`ARF_IRQ_DATA]    = accept;
        irq_ev[`ARF_IRQ_OVERRUN] = any_ov_set || (|cov_set);
        irq_ev[`ARF_IRQ_SLEEP]   = sleep_ev;
        irq_stat_next = irq_stat_reg;
        if (wr_irq_stat) begin
            irq_stat_next = irq_stat_reg & ~bus_wdata[`ARF_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | irq_ev;
        irq_next      = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_reg      <= irq_next;
        end
    end

    // ----------------------------------------
    // Read path and result store
    // ----------------------------------------
    logic [31:0] rd_alt;

    always_comb begin
        rd_alt = 32'h0000_0000;
        unique case (bus_addr)
            `ARF_OFS_MODE:     rd_alt[`ARF_MODE_SLEEP] = sleep_sel_reg;
            `ARF_OFS_CHEN:     rd_alt[7:0] = chen_reg;
            `ARF_OFS_STATUS: begin
                rd_alt[`ARF_ST_EOC_LO +: 8] = eoc_reg;
                rd_alt[`ARF_ST_COV_LO +: 8] = cov_reg;
                rd_alt[`ARF_ST_NEW_DATA]    = new_data_reg;
                rd_alt[`ARF_ST_ANY_OV]      = any_ov_reg;
                rd_alt[`ARF_ST_ASLEEP]      = pwr_reg == arf_pkg::ARF_ASLEEP;
            end
            `ARF_OFS_LAST: begin
                rd_alt[`ARF_DATA_W-1:0]        = last_data_reg;
                rd_alt[`ARF_LAST_CHAN_LO +: 3] = last_chan_reg;
            end
            `ARF_OFS_IRQ_STAT: rd_alt[`ARF_IRQ_W-1:0] = irq_stat_reg;
            `ARF_OFS_IRQ_MASK: rd_alt[`ARF_IRQ_W-1:0] = irq_mask_reg;
            default:           rd_alt = 32'h0000_0000;
        endcase
    end

    // Channel result written in the same edge as the flags
    arf_result_mem u_mem (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .wr_en      (accept),
        .wr_addr    (eoc_chan),
        .wr_data    (eoc_data),
        .rd_en      (bus_rd),
        .rd_sel_mem (rd_chan),
        .rd_addr    (rd_ch),
        .rd_alt     (rd_alt),
        .rd_data    (bus_rdata)
    );

    assign start_conv   = start_reg;
    assign analog_sleep = pwr_reg == arf_pkg::ARF_ASLEEP;
    assign chan_enable  = chen_reg;
    assign irq          = irq_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_conv_end;
        eoc_pulse && sleep_sel_reg && !start_next && pwr_reg == arf_pkg::ARF_AWAKE;
    endsequence
    sequence s_stay_asleep;
        analog_sleep && !start_conv;
    endsequence

    chk_ndf_last_clear: assert property (rd_last && !accept |=> !new_data_reg)
        else $error("new data flag not cleared by last-result read");
    chk_ndf_chan_keep: assert property (rd_chan && new_data_reg |=> new_data_reg)
        else $error("channel read disturbed new data flag");
    chk_ndf_disabled: assert property (
        eoc_pulse && !chen_next[eoc_chan] && rd_last |=> !new_data_reg)
        else $error("disabled channel raised new data flag");
    chk_ndf_set: assert property (accept |=> new_data_reg && eoc_reg[$past(eoc_chan)])
        else $error("accepted conversion did not flag new data");
    chk_aov_status: assert property (rd_status && !any_ov_set |=> !any_ov_reg)
        else $error("status read did not clear general overrun");
    chk_aov_set: assert property (accept && new_data_reg |=> any_ov_reg)
        else $error("general overrun missed");
    chk_cov_set: assert property (accept && eoc_reg[eoc_chan] |=> cov_reg[$past(eoc_chan)])
        else $error("channel overrun missed");
    chk_cov_clear: assert property (
        rd_status && !(accept && eoc_reg[eoc_chan]) |=> cov_reg == 8'h00)
        else $error("status read did not clear channel overrun");
    chk_eoc_own_clear: assert property (
        rd_chan && !(accept && eoc_chan == rd_ch) |=> !eoc_reg[$past(rd_ch)])
        else $error("channel read did not clear its completion");
    chk_eoc_disabled: assert property (
        eoc_pulse && !chen_next[eoc_chan] && !eoc_reg[eoc_chan]
        |=> !eoc_reg[$past(eoc_chan)])
        else $error("disabled channel raised completion");
    chk_eoc_others: assert property (rd_chan && !rd_last
        |=> ($past(eoc_reg) & ~chan_onehot($past(rd_ch)) & ~eoc_reg) == 8'h00)
        else $error("channel read cleared another completion");
    chk_last_store: assert property (accept |=> last_data_reg == $past(eoc_data))
        else $error("accepted result not stored as last result");
    chk_aov_disable: assert property (wr_chen && accept && new_data_reg |=> any_ov_reg)
        else $error("general overrun missed beside a channel disable");
    chk_irq_set_wins: assert property (accept |=> irq_stat_reg[`ARF_IRQ_DATA])
        else $error("data interrupt event lost");
    chk_sleep_entry: assert property (s_conv_end |=> s_stay_asleep)
        else $error("sleep not entered at conversion end");
    chk_sleep_cause: assert property ($rose(analog_sleep) |-> $past(eoc_pulse))
        else $error("sleep entered without conversion end");
endmodule
`default_nettype wire

// File: testbench/arf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module arf_core_model #(
    parameter int CONV_CYC = 6
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Bench command, completion in the cycle after the taking edge
    input  wire logic               cmd_valid,
    input  wire arf_pkg::arf_chan_t cmd_chan,
    input  wire arf_pkg::arf_data_t cmd_data,
    // Controller side
    input  wire logic               start_conv,
    input  wire logic [7:0]         chan_enable,
    output logic                    eoc_pulse,
    output arf_pkg::arf_chan_t      eoc_chan,
    output arf_pkg::arf_data_t      eoc_data
);
    int                 busy_cnt;
    arf_pkg::arf_chan_t run_chan;

    // ----------------------------------------
    // Conversion sequencing
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eoc_pulse <= 1'b0;
            eoc_chan  <= 3'h0;
            eoc_data  <= 10'h000;
            busy_cnt  <= 0;
            run_chan  <= 3'h0;
        end else begin
            eoc_pulse <= 1'b0;
            // Lines toggle outside a completion, so stale values never look valid
            eoc_chan  <= ~eoc_chan;
            eoc_data  <= ~eoc_data;
            if (busy_cnt > 0) begin
                busy_cnt <= busy_cnt - 1;
            end
            if (cmd_valid) begin
                eoc_pulse <= 1'b1;
                eoc_chan  <= cmd_chan;
                eoc_data  <= cmd_data;
            end else if (busy_cnt == 1) begin
                eoc_pulse <= 1'b1;
                eoc_chan  <= run_chan;
                eoc_data  <= {7'h00, run_chan} ^ 10'h2A0;
            end
            if (start_conv) begin
                busy_cnt <= CONV_CYC;
                run_chan <= 3'h0;
                for (int i = 7; i >= 0; i--) begin
                    if (chan_enable[i]) begin
                        run_chan <= 3'(i);
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "arf_map.svh"
module tb_top;
    logic               ref_clk;
    logic               rst;
    arf_pkg::arf_addr_t bus_addr;
    logic [31:0]        bus_wdata;
    logic               bus_wr;
    logic               bus_rd;
    logic [31:0]        bus_rdata;
    logic               eoc_pulse;
    arf_pkg::arf_chan_t eoc_chan;
    arf_pkg::arf_data_t eoc_data;
    logic               start_conv;
    logic               analog_sleep;
    logic [7:0]         chan_enable;
    logic               irq;
    logic               cmd_valid;
    arf_pkg::arf_chan_t cmd_chan;
    arf_pkg::arf_data_t cmd_data;
    int                 mismatches;
    int                 tests_run;
    logic [31:0]        rv;

    arf_flag_ctrl dut (
        .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .eoc_pulse(eoc_pulse),
        .eoc_chan(eoc_chan), .eoc_data(eoc_data), .start_conv(start_conv),
        .analog_sleep(analog_sleep), .chan_enable(chan_enable), .irq(irq)
    );
    arf_core_model core (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_chan(cmd_chan),
        .cmd_data(cmd_data), .start_conv(start_conv), .chan_enable(chan_enable),
        .eoc_pulse(eoc_pulse), .eoc_chan(eoc_chan), .eoc_data(eoc_data)
    );

    // ----------------------------------------
    // Checking and access tasks
    // ----------------------------------------
    task automatic end_sim();
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Also drops a pending core command at its first edge
    task automatic bus_op(input logic wr, input arf_pkg::arf_addr_t a, input logic [31:0] d);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        bus_wr    <= wr;
        bus_rd    <= !wr;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        #1;
        rv = bus_rdata;
    endtask
    task automatic wr(input arf_pkg::arf_addr_t a, input logic [31:0] d);
        bus_op(1'b1, a, d);
    endtask
    task automatic rd(input string name, input arf_pkg::arf_addr_t a, input logic [31:0] exp);
        bus_op(1'b0, a, 32'h0000_0000);
        chk32(name, exp, rv);
    endtask
    task automatic send(input arf_pkg::arf_chan_t ch, input arf_pkg::arf_data_t d);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_chan  <= ch;
        cmd_data  <= d;
    endtask
    task automatic conv(input arf_pkg::arf_chan_t ch, input arf_pkg::arf_data_t d);
        send(ch, d);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask
    // Completion lands on the same edge that takes the strobe
    task automatic op_evt(input logic w, input arf_pkg::arf_addr_t a, input logic [31:0] d,
                          input arf_pkg::arf_chan_t ch, input arf_pkg::arf_data_t cd);
        send(ch, cd);
        bus_op(w, a, d);
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst        = 1'b1;
        bus_addr   = 8'h00;
        bus_wdata  = 32'h0;
        bus_wr     = 1'b0;
        bus_rd     = 1'b0;
        cmd_valid  = 1'b0;
        cmd_chan   = 3'h0;
        cmd_data   = 10'h000;
        mismatches = 0;
        tests_run  = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd("chen", `ARF_OFS_CHEN, 32'h0);
        rd("mask", `ARF_OFS_IRQ_MASK, 32'h0);
        rd("mode", `ARF_OFS_MODE, 32'h0);
        rd("ctrl", `ARF_OFS_CTRL, 32'h0);
        rd("status", `ARF_OFS_STATUS, 32'h0);
        rd("unmapped", 8'h30, 32'h0);
        chk1("irq", 1'b0, irq);
        wr(`ARF_OFS_CHEN, 32'h07);
        chk32("chan_enable", 32'h07, {24'h0, chan_enable});
        conv(1, 10'h155);
        rd("status", `ARF_OFS_STATUS, 32'h0001_0002);
        rd("chdata1", 8'h44, 32'h155);
        rd("status", `ARF_OFS_STATUS, 32'h0001_0000);
        rd("last", `ARF_OFS_LAST, 32'h1155);
        rd("status", `ARF_OFS_STATUS, 32'h0);
        conv(0, 10'h111);
        op_evt(1'b0, `ARF_OFS_LAST, 32'h0, 5, 10'h3C3);
        rd("status", `ARF_OFS_STATUS, 32'h0);
        conv(0, 10'h111);
        conv(1, 10'h222);
        conv(2, 10'h333);
        rd("status", `ARF_OFS_STATUS, 32'h0003_0007);
        op_evt(1'b0, 8'h40, 32'h0, 1, 10'h0AB);
        chk32("chdata0", 32'h111, rv);
        rd("status", `ARF_OFS_STATUS, 32'h0003_0206);
        rd("last", `ARF_OFS_LAST, 32'h10AB);
        rd("status", `ARF_OFS_STATUS, 32'h0000_0004);
        conv(0, 10'h111);
        conv(0, 10'h222);
        rd("chdata0", 8'h40, 32'h222);
        op_evt(1'b0, `ARF_OFS_STATUS, 32'h0, 0, 10'h333);
        rd("status", `ARF_OFS_STATUS, 32'h0003_0005);
        conv(1, 10'h0AB);
        rd("last", `ARF_OFS_LAST, 32'h10AB);
        op_evt(1'b0, `ARF_OFS_STATUS, 32'h0, 1, 10'h111);
        rd("status", `ARF_OFS_STATUS, 32'h0001_0007);
        rd("chdata2", 8'h48, 32'h333);
        op_evt(1'b1, `ARF_OFS_CHEN, 32'h03, 1, 10'h222);
        rd("status", `ARF_OFS_STATUS, 32'h0003_0203);
        rd("chdata1", 8'h44, 32'h222);
        rd("last", `ARF_OFS_LAST, 32'h1222);
        op_evt(1'b0, 8'h40, 32'h0, 2, 10'h0AB);
        chk32("chdata0", 32'h333, rv);
        rd("status", `ARF_OFS_STATUS, 32'h0);
        rd("irq_stat", `ARF_OFS_IRQ_STAT, 32'h3);
        wr(`ARF_OFS_IRQ_MASK, 32'h1);
        settle();
        chk1("irq", 1'b1, irq);
        wr(`ARF_OFS_IRQ_STAT, 32'h3);
        settle();
        chk1("irq", 1'b0, irq);
        rd("irq_stat", `ARF_OFS_IRQ_STAT, 32'h0);
        conv(0, 10'h111);
        settle();
        chk1("irq", 1'b1, irq);
        wr(`ARF_OFS_IRQ_MASK, 32'h0);
        settle();
        chk1("irq", 1'b0, irq);
        // Sleep chosen while idle must wait for a completion
        wr(`ARF_OFS_MODE, 32'h1);
        rd("mode", `ARF_OFS_MODE, 32'h1);
        repeat (5) @(posedge ref_clk);
        #1;
        chk1("analog_sleep", 1'b0, analog_sleep);
        wr(`ARF_OFS_CTRL, 32'h1);
        chk1("start_conv", 1'b1, start_conv);
        for (int i = 0; i < 50 && analog_sleep !== 1'b1; i++) @(posedge ref_clk);
        if (analog_sleep !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        rd("status", `ARF_OFS_STATUS, 32'h0007_0101);
        chk1("asleep", 1'b1, rv[`ARF_ST_ASLEEP]);
        rd("irq_stat", `ARF_OFS_IRQ_STAT, 32'h0000_0007);
        chk1("sleep_irq", 1'b1, rv[`ARF_IRQ_SLEEP]);
        wr(`ARF_OFS_MODE, 32'h0);
        settle();
        chk1("analog_sleep", 1'b0, analog_sleep);
        end_sim();
    end
endmodule
`default_nettype wire
